// *** design/decode_pkg.sv ***
`default_nettype none
package decode_pkg;
	// ------------------------------------------------------------
	// instruction word layout
	// ------------------------------------------------------------
	localparam int          INSN_W        = 14;     // program word width
	localparam int          PC_W          = 13;     // program counter width
	localparam int          DATA_W        = 8;      // data path width
	localparam int          FADDR_W       = 7;      // file address width
	localparam int          IRQ_EN_BIT    = 7;      // enable bit in irq control reg
	// literal load: 11 00xx kkkk kkkk
	localparam logic [13:0] LIT_MASK      = 14'h3C00;
	localparam logic [13:0] LIT_CODE      = 14'h3000;
	// store working: 00 0000 1fff ffff
	localparam logic [13:0] STW_MASK      = 14'h3F80;
	localparam logic [13:0] STW_CODE      = 14'h0080;
	// no operation: 00 0000 0xx0 0000
	localparam logic [13:0] IDLE_MASK     = 14'h3F9F;
	localparam logic [13:0] IDLE_CODE     = 14'h0000;
	// interrupt return: 00 0000 0000 1001
	localparam logic [13:0] RFI_CODE      = 14'h0009;
	// reset values
	localparam logic [7:0]  W_RESET       = 8'h00;
	localparam logic [12:0] PC_RESET      = 13'h0000;
	localparam logic [7:0]  IRQCTL_RESET  = 8'h00;
	// cycle counts
	localparam int          RFI_CYCLES    = 2;      // interrupt return length
	// decoded operation classes
	typedef enum logic [2:0] {
		OP_NONE, OP_LIT, OP_STW, OP_IDLE, OP_RFI
	} op_t;
endpackage : decode_pkg
`default_nettype wire

// *** design/move_nop_return_decode.sv ***
// Notes on behaviour
// - literal load writes literal into working register
// - store working copies W to file register
// - interrupt return pops stack into PC
// - interrupt return sets global irq enable bit
// - interrupt return takes two instruction cycles
`default_nettype none
module move_nop_return_decode
	import decode_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic [INSN_W-1:0]  insn,
	input  wire logic               insn_valid,
	input  wire logic [PC_W-1:0]    stack_top,
	output logic      [DATA_W-1:0]  working_ff,
	output logic                    file_we_ff,
	output logic      [FADDR_W-1:0] file_addr_ff,
	output logic      [DATA_W-1:0]  file_wdata_ff,
	output logic                    stack_pop_ff,
	output logic      [PC_W-1:0]    pc_ff,
	output logic      [DATA_W-1:0]  irq_control_reg_ff,
	output logic                    busy_ff,
	output logic                    done_ff,
	output logic                    unknown_op_ff
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	op_t op;                                         // class of current word
	logic take;                                      // word accepted this cycle
	assign take = insn_valid && !busy_ff;

	// don't-care bits of literal load are masked out, so any value executes
	always_comb begin
		if ((insn & LIT_MASK) == LIT_CODE) begin
			op = OP_LIT;
		end else if ((insn & STW_MASK) == STW_CODE) begin
			op = OP_STW;
		end else if (insn == RFI_CODE) begin
			op = OP_RFI;
		end else if ((insn & IDLE_MASK) == IDLE_CODE) begin
			op = OP_IDLE;
		end else begin
			op = OP_NONE;                            // outside this block
		end
	end

	// ------------------------------------------------------------
	// sequencing
	// ------------------------------------------------------------
	// second cycle of interrupt return; a word offered while busy is not taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= take && (op == OP_RFI);
		end
	end

	// completion pulse: single-cycle ops at once, return after its 2nd cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= busy_ff || (take && (op == OP_LIT || op == OP_STW
				|| op == OP_IDLE));
		end
	end

	// flag for words this block does not execute
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			unknown_op_ff <= 1'b0;
		end else begin
			unknown_op_ff <= take && (op == OP_NONE);
		end
	end

	// ------------------------------------------------------------
	// working register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			working_ff <= W_RESET;
		end else if (take && op == OP_LIT) begin
			working_ff <= insn[DATA_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// file register write port
	// ------------------------------------------------------------
	// one-cycle strobe; data is W as it stood when the word was taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			file_we_ff    <= 1'b0;
			file_addr_ff  <= '0;
			file_wdata_ff <= '0;
		end else begin
			file_we_ff <= take && (op == OP_STW);
			if (take && op == OP_STW) begin
				file_addr_ff  <= insn[FADDR_W-1:0];
				file_wdata_ff <= working_ff;
			end
		end
	end

	// ------------------------------------------------------------
	// stack and program counter
	// ------------------------------------------------------------
	// pop is a one-cycle pulse in the second (busy) cycle of the return
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stack_pop_ff <= 1'b0;
		end else begin
			stack_pop_ff <= take && (op == OP_RFI);
		end
	end

	// pc advances on single-cycle ops; return loads the stack top
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pc_ff <= PC_RESET;
		end else if (take && op == OP_RFI) begin
			pc_ff <= stack_top;
		end else if (take && op != OP_NONE) begin
			pc_ff <= pc_ff + PC_W'(1);
		end
	end

	// ------------------------------------------------------------
	// interrupt control register
	// ------------------------------------------------------------
	// only the enable bit is touched; other bits belong elsewhere
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_control_reg_ff <= IRQCTL_RESET;
		end else if (take && op == OP_RFI) begin
			irq_control_reg_ff[IRQ_EN_BIT] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_rfi_taken;
		take && op == OP_RFI;
	endsequence

	sequence s_rfi_done;
		busy_ff ##1 (done_ff && !busy_ff);
	endsequence

	chk_literal_load: assert property (@(posedge clk) disable iff (sys_rst)
		take && op == OP_LIT |=> working_ff == $past(insn[DATA_W-1:0]))
		else $error("literal not loaded");

	chk_store_write: assert property (@(posedge clk) disable iff (sys_rst)
		take && op == OP_STW |=> file_we_ff && file_wdata_ff == $past(working_ff)
			&& file_addr_ff == $past(insn[FADDR_W-1:0]))
		else $error("store write wrong");

	chk_return_pc: assert property (@(posedge clk) disable iff (sys_rst)
		s_rfi_taken |=> stack_pop_ff && pc_ff == $past(stack_top))
		else $error("return pc wrong");

	chk_return_gie: assert property (@(posedge clk) disable iff (sys_rst)
		s_rfi_taken |=> irq_control_reg_ff[IRQ_EN_BIT])
		else $error("enable not set");

	chk_return_len: assert property (@(posedge clk) disable iff (sys_rst)
		s_rfi_taken |=> s_rfi_done)
		else $error("return not two cycles");

	chk_single_cycle: assert property (@(posedge clk) disable iff (sys_rst)
		take && (op == OP_LIT || op == OP_IDLE) |=> done_ff && !busy_ff)
		else $error("op not single cycle");

	chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		take && op == OP_IDLE |=> $stable(working_ff) && !file_we_ff && !stack_pop_ff)
		else $error("idle op changed state");

	chk_pop_single: assert property (@(posedge clk) disable iff (sys_rst)
		stack_pop_ff |=> !stack_pop_ff)
		else $error("pop held too long");

	// single-cycle ops step the program counter by exactly one
	chk_pc_step: assert property (@(posedge clk) disable iff (sys_rst)
		take && (op == OP_LIT || op == OP_STW || op == OP_IDLE)
			|=> pc_ff == $past(pc_ff) + PC_W'(1))
		else $error("pc did not step");

	// store finishes at once and leaves the working register alone
	chk_store_len: assert property (@(posedge clk) disable iff (sys_rst)
		take && op == OP_STW |=> done_ff && !busy_ff && $stable(working_ff))
		else $error("store not single cycle");

	// done of a return lands exactly its cycle count after the take
	localparam int RET_LEN = RFI_CYCLES;             // cycles from take to done
	chk_return_done: assert property (@(posedge clk) disable iff (sys_rst)
		s_rfi_taken |-> ##RET_LEN done_ff)
		else $error("return done late");

	// a word offered while busy must leave no trace at all
	chk_busy_refuse: assert property (@(posedge clk) disable iff (sys_rst)
		busy_ff |=> $stable(working_ff) && $stable(pc_ff)
			&& !file_we_ff && !stack_pop_ff)
		else $error("word taken while busy");

	// only a return may touch the interrupt control register
	chk_irq_steady: assert property (@(posedge clk) disable iff (sys_rst)
		!(take && op == OP_RFI) |=> $stable(irq_control_reg_ff))
		else $error("irq control changed");

	// words outside this block only raise their flag
	chk_unknown_hold: assert property (@(posedge clk) disable iff (sys_rst)
		take && op == OP_NONE |=> unknown_op_ff && $stable(pc_ff) && !done_ff)
		else $error("unknown word executed");
endmodule : move_nop_return_decode
`default_nettype wire

// *** tb/fetch_model.sv ***
`default_nettype none
module fetch_model
	import decode_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              offer,
	input  wire logic [INSN_W-1:0] word,
	output logic      [INSN_W-1:0] insn,
	output logic                   insn_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// fetch path: word shows one cycle after offer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		insn_valid <= offer;
		insn       <= offer ? word : ~insn; // idle bus toggles between the last word and its inverse
	end
endmodule : fetch_model
`default_nettype wire

// *** tb/move_nop_return_decode_test.sv ***
`default_nettype none
module move_nop_return_decode_test
	import decode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk = 0;      // instruction clock
	logic              sys_rst = 1;  // sync reset
	logic              offer = 0;    // ask fetch path for a word
	logic [INSN_W-1:0] word = '0;    // word to present
	logic [INSN_W-1:0] insn;         // presented word
	logic              insn_valid;   // word present
	logic [PC_W-1:0]   stack_top = 13'h1ABC;
	logic [DATA_W-1:0] w_q, d_q, irq_q;
	logic [FADDR_W-1:0] a_q;         // file address seen
	logic [PC_W-1:0]   pc_q;
	logic              we_q, pop_q, busy_q, done_q, unk_q;
	int                errors = 0;   // mismatches
	int                compares = 0; // comparisons
	logic [PC_W-1:0]   exp_pc = '0;  // expected program counter
	logic [DATA_W-1:0] exp_w = '0;   // expected working register
	logic [DATA_W-1:0] exp_irq = '0; // expected irq control register
	always #5 clk = ~clk;
	// ----------------------------------------
	// parts
	// ----------------------------------------
	fetch_model i_fetch_model (.clk(clk), .offer(offer), .word(word), .insn(insn),
		.insn_valid(insn_valid));
	move_nop_return_decode i_move_nop_return_decode (
		.clk(clk), .sys_rst(sys_rst), .insn(insn), .insn_valid(insn_valid),
		.stack_top(stack_top), .working_ff(w_q), .file_we_ff(we_q), .file_addr_ff(a_q),
		.file_wdata_ff(d_q), .stack_pop_ff(pop_q), .pc_ff(pc_q), .irq_control_reg_ff(irq_q),
		.busy_ff(busy_q), .done_ff(done_q), .unknown_op_ff(unk_q));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// offer one word; returns just after the edge where it was taken
	task automatic issue(input logic [INSN_W-1:0] w);
		@(posedge clk) begin
			offer <= 1'b1;
			word <= w;
		end
		@(posedge clk) offer <= 1'b0;
		@(posedge clk) #1;
	endtask : issue
	// single-cycle op: pc steps, done pulses, W and irq control as expected
	task automatic single(input logic [INSN_W-1:0] w);
		issue(w);
		exp_pc++;
		chk("pc", pc_q, exp_pc);
		chk("done", done_q, 1'b1);
		chk("work", w_q, exp_w);
		chk("irq", irq_q, exp_irq);
	endtask : single
	task automatic finish_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_lit_store;
		logic [7:0] k [2] = '{8'h5A, 8'hFF};
		logic [6:0] f [2] = '{7'h7F, 7'h00};
		for (int i = 0; i < 2; i++) begin
			exp_w = k[i];
			single({6'h30, k[i]});
			single({7'h01, f[i]});
			chk("we", we_q, 1'b1);
			chk("addr", a_q, f[i]);
			chk("wdata", d_q, k[i]);
		end
	endtask : t_lit_store
	task automatic t_idle_unknown;
		single(14'h0000);
		single(14'h0060);
		issue(14'h3FFF);
		chk("unk", unk_q, 1'b1);
		chk("pc_unk", pc_q, exp_pc);
	endtask : t_idle_unknown
	task automatic t_return;
		issue(RFI_CODE);
		chk("pc_ret", pc_q, stack_top);
		chk("pop", pop_q, 1'b1);
		exp_irq[IRQ_EN_BIT] = 1'b1;
		chk("irq_en", irq_q[IRQ_EN_BIT], 1'b1);
		chk("irq_ret", irq_q, exp_irq);
		chk("busy", busy_q, 1'b1);
		chk("done1", done_q, 1'b0);
		@(posedge clk) #1;
		chk("done2", done_q, 1'b1);
		chk("busy2", busy_q, 1'b0);
		chk("work_r", w_q, exp_w);
		exp_pc = stack_top;
		single(14'h0000);
	endtask : t_return
	// second word offered in the return's busy cycle is dropped
	task automatic t_busy_refuse;
		@(posedge clk) begin
			offer <= 1'b1;
			word <= RFI_CODE;
			stack_top <= 13'h0555;
		end
		@(posedge clk) word <= {6'h30, 8'hC3};
		@(posedge clk) offer <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("pc_busy", pc_q, 13'h0555);
		chk("work_busy", w_q, exp_w);
		chk("done_busy", done_q, 1'b0);
		exp_pc = 13'h0555;
	endtask : t_busy_refuse
	// reset in mid-run brings pc, W, irq control and the five flags back
	task automatic t_reset_mid;
		@(posedge clk) sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk("pc_rst", pc_q, PC_RESET);
		chk("work_rst", w_q, W_RESET);
		chk("irq_rst", irq_q, IRQCTL_RESET);
		chk("flags_rst", {we_q, pop_q, busy_q, done_q, unk_q}, 5'h00);
		exp_pc = PC_RESET;
		exp_w = W_RESET;
		exp_irq = IRQCTL_RESET;
		single(14'h0000);
	endtask : t_reset_mid
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		t_lit_store();
		t_idle_unknown();
		t_return();
		t_busy_refuse();
		t_reset_mid();
		finish_test();
	end
	initial begin
		#5000;
		errors++;
		finish_test();
	end
endmodule : move_nop_return_decode_test
`default_nettype wire
